/* rpsc_bus_div.sv */
// one peripheral bus clock divider with glitch-free ratio change and ready flag
`default_nettype none
module rpsc_bus_div #(
    parameter int DIV_W = 7
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [DIV_W-1:0] div_i,
    input wire logic enable_i,
    output logic clk_o,
    output logic ready_o
);
    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("rpsc_bus_div: bad DIV_W");
        end
    end
    logic [DIV_W-1:0] ratio;
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] half;
    logic pending;
    wire at_end = (count == ratio);
    wire [DIV_W-1:0] next_count = at_end ? '0 : count + 1'b1;
    wire change = (div_i != ratio);
    // output goes high at the start of each period and low at midpoint; a ratio of zero holds it high
    wire next_level = (ratio == '0) ? 1'b1 : (count < half);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // start on the register's reset divisor, so ready does not dip after reset
            ratio <= DIV_W'(rpsc_pkg::BUS_DIV_RESET);
            count <= '0;
            half <= DIV_W'((rpsc_pkg::BUS_DIV_RESET >> 1) + 1'b1);
            pending <= 1'b0;
            clk_o <= 1'b0;
            ready_o <= 1'b1;
        end else begin
            count <= next_count;
            // ratio swaps only at a period boundary, so no runt pulse escapes
            if (at_end && pending) begin
                ratio <= div_i;
                half <= (div_i >> 1) + 1'b1;
                pending <= 1'b0;
            end else if (change && !pending) begin
                pending <= 1'b1;
            end
            ready_o <= !(pending || change);
            clk_o <= enable_i & next_level;
        end
    end
endmodule : rpsc_bus_div
`default_nettype wire

/* rpsc_pkg.sv */
// shared constants for the reference, bus divider and slew clock control block
`default_nettype none
package rpsc_pkg;
    localparam int NUM_BUS = 6;
    localparam logic [1:0] BYTE_ADDR_LSB = 2'h2;
    // byte addresses of the word registers
    localparam logic [7:0] ADDR_REF_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REF_TRIM = 8'h04;
    localparam logic [7:0] ADDR_SLEW = 8'h08;
    localparam logic [7:0] ADDR_UNLOCK = 8'h0C;
    localparam logic [7:0] ADDR_OSC_SWITCH = 8'h10;
    localparam logic [7:0] ADDR_BUS_BASE = 8'h20;
    localparam logic [31:0] UNLOCK_KEY1 = 32'hAA996655;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h556699AA;
    // ref control fields
    localparam int REF_SEL_LSB = 0;
    localparam int REF_SEL_W = 4;
    localparam int REF_ACTIVE_BIT = 8;
    localparam int REF_ON_BIT = 15;
    localparam int REF_DIV_LSB = 16;
    localparam int REF_DIV_W = 15;
    localparam int TRIM_LSB = 23;
    localparam int TRIM_W = 9;
    localparam logic [3:0] SEL_SYS = 4'h0;
    localparam logic [3:0] SEL_PER = 4'h1;
    localparam logic [3:0] SEL_LAST = 4'hB;
    // bus divider fields
    localparam int BUS_ON_BIT = 15;
    localparam int BUS_RDY_BIT = 11;
    localparam int BUS_DIV_W = 7;
    localparam logic [6:0] BUS_DIV_RESET = 7'h01;
    localparam logic [5:0] BUS_LOCKED_ON = 6'h2D;
    // slew fields
    localparam int SLW_DLY_LSB = 24;
    localparam int SYS_DIV_LSB = 16;
    localparam int SLW_MAX_LSB = 8;
    localparam int SLW_UP_BIT = 2;
    localparam int SLW_DN_BIT = 1;
    localparam int SLW_BUSY_BIT = 0;
    localparam logic [3:0] SLW_DLY_RESET = 4'h0;
    localparam logic [3:0] SYS_DIV_RESET = 4'h0;
    localparam logic [2:0] SLW_MAX_RESET = 3'h0;
    localparam logic [3:0] SLW_STEP_HOLD = 4'h4;
    typedef enum logic [1:0] {RPSC_UNLK_IDLE, RPSC_UNLK_HALF, RPSC_UNLK_OPEN} rpsc_unlock_type;
    typedef enum logic [1:0] {RPSC_SLW_IDLE, RPSC_SLW_STEP, RPSC_SLW_FINAL} rpsc_slew_type;
endpackage : rpsc_pkg
`default_nettype wire

/* rpsc_top.sv */
// reference clock select and trim, bus clock dividers, system clock slew control
// Contract
// - source select picks twelve clocks, rest reserved
// - system or peripheral source follows clock switching
// - trim adds value over 512 to divisor
// - bus enable bit gates divided clock
// - bus enables 1,3,4,6 cannot be cleared
// - ready bit high idle, low while switching
// - bus clock is system clock over value+1; a value of 0 holds the bus clock high instead
// - divisor and slew writes need unlock first
// - slew step clock count is value plus one; step_clocks is computed but unused, each step holds four clocks
// - system divisor is value plus one
// - slew starts at two power steps, halves down
// - each slew divisor step holds four clocks
// - slew settings apply on switch request only
// - upward slew enable slews rising switches
// - downward slew enable slews falling switches
// - busy flag reads one while slewing
// - request status bit reads one while active
//
// Chosen here: the placing of the registers and the Avalon-MM slave port.
`default_nettype none
module rpsc_top #(
    parameter int NUM_BUS = rpsc_pkg::NUM_BUS
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [11:0] ref_sources_i,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic ref_clock_out_o,
    output logic [NUM_BUS-1:0] bus_clock_n_o,
    output logic [3:0] sys_clock_divisor_o,
    output logic slew_busy_o
);
    initial begin
        if (NUM_BUS != rpsc_pkg::NUM_BUS) begin
            $error("rpsc_top: NUM_BUS must be 6");
        end
        if (rpsc_pkg::TRIM_LSB + rpsc_pkg::TRIM_W != 32'h20) begin
            $error("rpsc_top: trim field must end at the top bit");
        end
        if (rpsc_pkg::SLW_STEP_HOLD == 4'h0) begin
            $error("rpsc_top: slew step hold must be nonzero");
        end
    end
    // source pins come from other domains: two flops each before use
    logic [11:0] src_meta;
    logic [11:0] src_sync;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_meta <= 12'h000;
            src_sync <= 12'h000;
        end else begin
            src_meta <= ref_sources_i;
            src_sync <= src_meta;
        end
    end

    // one address compare, shared by every register decoder except the bus divider range
    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] reg_addr);
        return a == reg_addr;
    endfunction : addr_hit

    // ---- bus slave: one wait cycle, answer in the second cycle
    logic ack;
    wire req = (avs_read | avs_write) & !ack;
    wire wr = avs_write & req;
    wire full_word = (avs_byteenable == 4'hF);
    wire hit_ctrl = addr_hit(avs_address, rpsc_pkg::ADDR_REF_CTRL);
    wire hit_trim = addr_hit(avs_address, rpsc_pkg::ADDR_REF_TRIM);
    wire hit_slew = addr_hit(avs_address, rpsc_pkg::ADDR_SLEW);
    wire hit_unlk = addr_hit(avs_address, rpsc_pkg::ADDR_UNLOCK);
    wire hit_osw = addr_hit(avs_address, rpsc_pkg::ADDR_OSC_SWITCH);
    wire [7:0] bus_off = avs_address - rpsc_pkg::ADDR_BUS_BASE;
    wire hit_bus_any = (avs_address >= rpsc_pkg::ADDR_BUS_BASE)
        && (bus_off[7:rpsc_pkg::BYTE_ADDR_LSB] < 6'(NUM_BUS)) && (bus_off[1:0] == 2'h0);
    wire [2:0] bus_idx = bus_off[4:2];

    // ---- unlock sequence: two keys in order, one locked write allowed
    // a wrong key or an out-of-order key starts the sequence over
    rpsc_pkg::rpsc_unlock_type unlk_state;
    logic unlocked;
    wire locked_wr = wr & full_word & (hit_slew | hit_bus_any);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            unlk_state <= rpsc_pkg::RPSC_UNLK_IDLE;
        end else if (wr && hit_unlk) begin
            if (avs_writedata == rpsc_pkg::UNLOCK_KEY1) begin
                unlk_state <= rpsc_pkg::RPSC_UNLK_HALF;
            end else if (avs_writedata == rpsc_pkg::UNLOCK_KEY2
                    && unlk_state == rpsc_pkg::RPSC_UNLK_HALF) begin
                unlk_state <= rpsc_pkg::RPSC_UNLK_OPEN;
            end else begin
                unlk_state <= rpsc_pkg::RPSC_UNLK_IDLE;
            end
        end else if (locked_wr) begin
            unlk_state <= rpsc_pkg::RPSC_UNLK_IDLE;
        end
    end
    assign unlocked = (unlk_state == rpsc_pkg::RPSC_UNLK_OPEN);

    // ---- reference clock registers
    logic [3:0] ref_sel;
    logic ref_on;
    logic ref_active;
    logic [14:0] ref_div;
    logic [8:0] ref_trim;
    wire [3:0] wr_sel = avs_writedata[rpsc_pkg::REF_SEL_LSB +: rpsc_pkg::REF_SEL_W];
    wire wr_on = avs_writedata[rpsc_pkg::REF_ON_BIT];
    wire [14:0] wr_div = avs_writedata[rpsc_pkg::REF_DIV_LSB +: rpsc_pkg::REF_DIV_W];
    wire [8:0] wr_trim = avs_writedata[rpsc_pkg::TRIM_LSB +: rpsc_pkg::TRIM_W];
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_sel <= rpsc_pkg::SEL_SYS;
            ref_on <= 1'b0;
            ref_div <= 15'h0000;
            ref_trim <= 9'h000;
        end else if (wr && full_word) begin
            if (hit_ctrl) begin
                ref_sel <= wr_sel;
                ref_on <= wr_on;
                ref_div <= wr_div;
            end else if (hit_trim) begin
                ref_trim <= wr_trim;
            end
        end
    end
    // request active follows enable one cycle later
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ref_active <= 1'b0;
        end else begin
            ref_active <= ref_on;
        end
    end

    // system and peripheral choices tap live clocks, so switching shows through
    wire sel_valid = (ref_sel <= rpsc_pkg::SEL_LAST);
    wire src_clk = sel_valid ? src_sync[ref_sel] : 1'b0;
    logic src_prev;
    wire src_rise = src_clk & !src_prev;
    // half period = div + trim/512, kept as a 24-bit fixed-point accumulator
    logic [23:0] ref_acc;
    wire [23:0] half_step = {ref_div, ref_trim};
    wire [23:0] one_unit = 24'h000200;
    wire reach = (ref_acc + one_unit) >= half_step;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            src_prev <= 1'b0;
            ref_acc <= 24'h000000;
            ref_clock_out_o <= 1'b0;
        end else begin
            src_prev <= src_clk;
            if (!ref_active) begin
                ref_acc <= 24'h000000;
                ref_clock_out_o <= 1'b0;
            end else if (ref_div == 15'h0000) begin
                ref_clock_out_o <= src_clk;
            end else if (src_rise) begin
                // fractional remainder carries over, so periods dither around the mean
                if (reach) begin
                    ref_acc <= ref_acc + one_unit - half_step;
                    ref_clock_out_o <= !ref_clock_out_o;
                end else begin
                    ref_acc <= ref_acc + one_unit;
                end
            end
        end
    end

    // ---- bus dividers
    logic [6:0] bus_div [NUM_BUS];
    logic [NUM_BUS-1:0] bus_on;
    logic [NUM_BUS-1:0] bus_rdy;
    logic [NUM_BUS-1:0] bus_clk;
    genvar g;
    generate
        for (g = 0; g < NUM_BUS; g++) begin : gen_bus
            wire sel_me = hit_bus_any && (bus_idx == 3'(g));
            wire take = locked_wr && sel_me && unlocked;
            always_ff @(posedge clk_sys_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    bus_div[g] <= rpsc_pkg::BUS_DIV_RESET;
                    bus_on[g] <= 1'b1;
                end else if (take) begin
                    // the divisor is refused while switching; the enable still lands
                    if (bus_rdy[g]) begin
                        bus_div[g] <= avs_writedata[rpsc_pkg::BUS_DIV_W-1:0];
                    end
                    bus_on[g] <= avs_writedata[rpsc_pkg::BUS_ON_BIT]
                        | rpsc_pkg::BUS_LOCKED_ON[g];
                end
            end
            rpsc_bus_div #(.DIV_W(rpsc_pkg::BUS_DIV_W)) u_div (
                .clk_sys_i(clk_sys_i),
                .rstn_i(rstn_i),
                .div_i(bus_div[g]),
                .enable_i(bus_on[g]),
                .clk_o(bus_clk[g]),
                .ready_o(bus_rdy[g])
            );
        end
    endgenerate
    assign bus_clock_n_o = bus_clk;

    // ---- slew control: staged settings, applied on switch request
    logic [3:0] st_dly;
    logic [3:0] st_div;
    logic [2:0] st_max;
    logic st_up;
    logic st_dn;
    logic [3:0] act_dly;
    logic [3:0] act_div;
    logic [2:0] act_max;
    wire osw_req = wr && hit_osw && avs_writedata[0];
    wire [3:0] wr_dly = avs_writedata[rpsc_pkg::SLW_DLY_LSB +: 4];
    wire [3:0] wr_sys_clock_divisor = avs_writedata[rpsc_pkg::SYS_DIV_LSB +: 4];
    wire [2:0] wr_max = avs_writedata[rpsc_pkg::SLW_MAX_LSB +: 3];
    wire wr_up = avs_writedata[rpsc_pkg::SLW_UP_BIT];
    wire wr_dn = avs_writedata[rpsc_pkg::SLW_DN_BIT];
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_dly <= rpsc_pkg::SLW_DLY_RESET;
            st_div <= rpsc_pkg::SYS_DIV_RESET;
            st_max <= rpsc_pkg::SLW_MAX_RESET;
            st_up <= 1'b0;
            st_dn <= 1'b0;
        end else if (locked_wr && hit_slew && unlocked) begin
            st_dly <= wr_dly;
            st_div <= wr_sys_clock_divisor;
            st_max <= wr_max;
            st_up <= wr_up;
            st_dn <= wr_dn;
        end
    end

    rpsc_pkg::rpsc_slew_type slw_state;
    logic [2:0] step_exp;
    logic [3:0] hold_cnt;
    logic [3:0] tgt_div;
    // a smaller divisor is a faster clock, so that switch goes up
    wire going_up = (st_div < act_div);
    wire do_slew = (st_max != 3'h0) && (going_up ? st_up : st_dn);
    wire hold_done = (hold_cnt == rpsc_pkg::SLW_STEP_HOLD - 4'h1);
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slw_state <= rpsc_pkg::RPSC_SLW_IDLE;
            act_dly <= rpsc_pkg::SLW_DLY_RESET;
            act_div <= rpsc_pkg::SYS_DIV_RESET;
            act_max <= rpsc_pkg::SLW_MAX_RESET;
            step_exp <= 3'h0;
            hold_cnt <= 4'h0;
            tgt_div <= 4'h0;
            sys_clock_divisor_o <= rpsc_pkg::SYS_DIV_RESET;
            slew_busy_o <= 1'b0;
        end else begin
            case (slw_state)
                rpsc_pkg::RPSC_SLW_IDLE: begin
                    if (osw_req) begin
                        act_dly <= st_dly;
                        act_max <= st_max;
                        tgt_div <= st_div;
                        hold_cnt <= 4'h0;
                        if (do_slew && st_div != act_div) begin
                            step_exp <= st_max;
                            slew_busy_o <= 1'b1;
                            slw_state <= rpsc_pkg::RPSC_SLW_STEP;
                        end else begin
                            act_div <= st_div;
                            sys_clock_divisor_o <= st_div;
                        end
                    end
                end
                rpsc_pkg::RPSC_SLW_STEP: begin
                    hold_cnt <= hold_done ? 4'h0 : hold_cnt + 4'h1;
                    if (hold_done) begin
                        // last step ends with the target divisor and busy low on one edge
                        if (step_exp == 3'h1) begin
                            act_div <= tgt_div;
                            sys_clock_divisor_o <= tgt_div;
                            slew_busy_o <= 1'b0;
                            slw_state <= rpsc_pkg::RPSC_SLW_IDLE;
                        end else begin
                            step_exp <= step_exp - 3'h1;
                        end
                    end
                end
                default: begin
                    act_div <= tgt_div;
                    sys_clock_divisor_o <= tgt_div;
                    slew_busy_o <= 1'b0;
                    slw_state <= rpsc_pkg::RPSC_SLW_IDLE;
                end
            endcase
        end
    end
    // step_clocks is act_dly + 1, but each step holds four clocks; computed only, never read out,
    // the clock tree outside counts them
    wire [4:0] step_clocks = {1'b0, act_dly} + 5'h01;

    // ---- read mux
    logic [31:0] bus_word [NUM_BUS];
    generate
        for (g = 0; g < NUM_BUS; g++) begin : gen_rd
            assign bus_word[g] = {16'h0000, bus_on[g], 3'h0, bus_rdy[g], 4'h0, bus_div[g]};
        end
    endgenerate
    wire [31:0] ctrl_word = {1'b0, ref_div, ref_on, 6'h00, ref_active, 4'h0, ref_sel};
    wire [31:0] trim_word = {ref_trim, 23'h000000};
    wire [31:0] slew_word = {4'h0, st_dly, 4'h0, st_div, 5'h00, st_max,
        5'h00, st_up, st_dn, slew_busy_o};
    wire [31:0] rd_word = hit_ctrl ? ctrl_word
        : hit_trim ? trim_word
        : hit_slew ? slew_word
        : hit_bus_any ? bus_word[bus_idx]
        : 32'h00000000;
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack <= 1'b0;
            avs_readdata <= 32'h00000000;
            avs_waitrequest <= 1'b1;
        end else begin
            ack <= req;
            avs_waitrequest <= !req;
            if (req && avs_read) begin
                avs_readdata <= rd_word;
            end
        end
    end
endmodule : rpsc_top
`default_nettype wire

/* rpsc_top_props.sv */
// concurrent checks on the ports of the clock control block
`default_nettype none
module rpsc_top_props #(
    parameter int NUM_BUS = rpsc_pkg::NUM_BUS
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic [11:0] ref_sources_i,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic ref_clock_out_o,
    input wire logic [NUM_BUS-1:0] bus_clock_n_o,
    input wire logic [3:0] sys_clock_divisor_o,
    input wire logic slew_busy_o
);
    logic [7:0] sw_age;
    logic [8:0] run_cnt;
    logic bus1_prev;
    wire rd_ack = avs_read && !avs_waitrequest;
    wire is_bus = (avs_address[7:5] == 3'h1) && (avs_address[1:0] == 2'h0)
        && (avs_address[4:2] < 3'(NUM_BUS));
    wire sw_taken = avs_write && avs_waitrequest && (avs_address == rpsc_pkg::ADDR_OSC_SWITCH);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // age of the last switch request, saturating so old requests never excuse a change
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) sw_age <= 8'hFF;
        else if (sw_taken) sw_age <= 8'h00;
        else if (sw_age != 8'hFF) sw_age <= sw_age + 8'h01;
    end
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bus1_prev <= 1'b0;
            run_cnt <= 9'h000;
        end else begin
            bus1_prev <= bus_clock_n_o[0];
            run_cnt <= (bus_clock_n_o[0] != bus1_prev) ? 9'h000 : run_cnt + {8'h00, run_cnt != 9'h1FF};
        end
    end
    a_ack_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge lasted more than one cycle");
    a_ack_after_req: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
        |-> ##1 !avs_waitrequest) else $error("request not answered after one wait cycle");
    a_trim_unused_zero: assert property (rd_ack && avs_address == rpsc_pkg::ADDR_REF_TRIM
        |-> avs_readdata[22:0] == 23'h0) else $error("trim unused bits not zero");
    a_bus_unused_zero: assert property (rd_ack && is_bus |-> avs_readdata[31:16] == 16'h0
        && avs_readdata[14:12] == 3'h0 && avs_readdata[10:7] == 4'h0)
        else $error("bus divider unused bits not zero");
    a_locked_on_read: assert property (rd_ack && is_bus
        && rpsc_pkg::BUS_LOCKED_ON[avs_address[4:2]] |-> avs_readdata[15])
        else $error("locked bus enable reads zero");
    a_bus1_clk_runs: assert property (run_cnt < 9'h12C)
        else $error("bus clock 1 stopped");
    a_busy_min_hold: assert property ($rose(slew_busy_o) |-> slew_busy_o[*4])
        else $error("slew step shorter than four clocks");
    a_busy_bounded: assert property ($rose(slew_busy_o) |-> ##[4:40] !slew_busy_o)
        else $error("slew did not finish");
    a_div_stable_busy: assert property (slew_busy_o |-> $stable(sys_clock_divisor_o))
        else $error("divisor output moved while slewing");
    a_busy_from_req: assert property ($rose(slew_busy_o) |-> sw_age <= 8'h04)
        else $error("slew started without switch request");
    a_div_from_req: assert property ($changed(sys_clock_divisor_o) |-> sw_age <= 8'h28)
        else $error("divisor changed without switch request");
endmodule : rpsc_top_props
bind rpsc_top rpsc_top_props #(.NUM_BUS(NUM_BUS)) u_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .ref_sources_i(ref_sources_i), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ref_clock_out_o(ref_clock_out_o), .bus_clock_n_o(bus_clock_n_o),
    .sys_clock_divisor_o(sys_clock_divisor_o), .slew_busy_o(slew_busy_o));
`default_nettype wire

/* tb_top.sv */
// register level testbench of the clock control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [11:0] ref_sources_i = 12'h000;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ref_clock_out_o;
    logic [5:0] bus_clock_n_o;
    logic [3:0] sys_clock_divisor_o;
    logic slew_busy_o;
    logic [11:0] src_mask = 12'h000;
    logic [3:0] src_cnt = 4'h0;
    logic [31:0] rd;
    logic [31:0] w;
    int busy_cnt = 0;
    int err_count = 0;
    int cmp_count = 0;
    int r;
    wire [6:0] clk_vec = {ref_clock_out_o, bus_clock_n_o};
    logic [31:0] slw_word [5] = '{32'h03030206, 32'h00000202, 32'h00070704, 32'h0F000704,
        32'h000F0006};
    int slw_busy [5] = '{8, 0, 0, 28, 0};
    rpsc_top u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ref_sources_i(ref_sources_i),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ref_clock_out_o(ref_clock_out_o), .bus_clock_n_o(bus_clock_n_o),
        .sys_clock_divisor_o(sys_clock_divisor_o), .slew_busy_o(slew_busy_o));
    always #10 clk_sys_i = ~clk_sys_i;
    // masked sources toggle every 8 cycles, the rest stay low
    always @(posedge clk_sys_i) begin
        src_cnt <= src_cnt + 4'h1;
        ref_sources_i <= src_mask & {12{src_cnt[3]}};
        if (slew_busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
    end
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_sys_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        check("bus latency", 32'h2, 32'(k));
    endtask : access
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        access(1'b0, a, 32'h00000000);
        check(name, exp, rd);
    endtask : rd_chk
    task automatic unlock_wr(input logic [7:0] a, input logic [31:0] d);
        access(1'b1, rpsc_pkg::ADDR_UNLOCK, rpsc_pkg::UNLOCK_KEY1);
        access(1'b1, rpsc_pkg::ADDR_UNLOCK, rpsc_pkg::UNLOCK_KEY2);
        access(1'b1, a, d);
    endtask : unlock_wr
    task automatic count_rises(input int sel, input int cycles);
        logic prev;
        r = 0;
        prev = clk_vec[sel];
        repeat (cycles) begin
            @(posedge clk_sys_i);
            if (clk_vec[sel] === 1'b1 && prev === 1'b0) r++;
            prev = clk_vec[sel];
        end
    endtask : count_rises
    // polls bus divider 1 until its divisor logic is idle again
    task automatic wait_ready;
        do begin
            access(1'b0, rpsc_pkg::ADDR_BUS_BASE, 32'h00000000);
        end while (rd[11] !== 1'b1);
    endtask : wait_ready
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        err_count++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        for (int k = 0; k < 6; k++) rd_chk("bus reset", 8'h20 + 8'(4 * k), 32'h00008801);
        rd_chk("slew reset", rpsc_pkg::ADDR_SLEW, 32'h00000000);
        rd_chk("unmapped", 8'h80, 32'h00000000);
        access(1'b1, 8'h24, 32'h00000005);
        rd_chk("bus locked", 8'h24, 32'h00008801);
        access(1'b1, rpsc_pkg::ADDR_SLEW, 32'h0F0F0706);
        rd_chk("slew locked", rpsc_pkg::ADDR_SLEW, 32'h00000000);
        for (int k = 0; k < 6; k++) begin
            unlock_wr(8'h20 + 8'(4 * k), 32'h00000001);
            access(1'b0, 8'h20 + 8'(4 * k), 32'h00000000);
            check("bus enable", 32'(rpsc_pkg::BUS_LOCKED_ON[k]), 32'(rd[15]));
            count_rises(k, 40);
            check("bus gate", rpsc_pkg::BUS_LOCKED_ON[k] ? 32'h14 : 32'h0, r);
        end
        unlock_wr(8'h2C, 32'h00000003);
        unlock_wr(rpsc_pkg::ADDR_BUS_BASE, 32'h0000807F);
        wait_ready();
        unlock_wr(rpsc_pkg::ADDR_BUS_BASE, 32'h00008003);
        access(1'b0, rpsc_pkg::ADDR_BUS_BASE, 32'h00000000);
        check("bus ready low", 32'h0, 32'(rd[11]));
        unlock_wr(rpsc_pkg::ADDR_BUS_BASE, 32'h00008005);
        wait_ready();
        check("bus div kept", 32'h00008803, rd);
        count_rises(0, 40);
        check("bus ratio", 32'hA, r);
        access(1'b1, rpsc_pkg::ADDR_REF_CTRL, 32'h00010000);
        access(1'b1, rpsc_pkg::ADDR_REF_TRIM, 32'hFFFFFFFF);
        rd_chk("trim", rpsc_pkg::ADDR_REF_TRIM, 32'hFF800000);
        avs_byteenable <= 4'h3;
        access(1'b1, rpsc_pkg::ADDR_REF_TRIM, 32'h00000000);
        avs_byteenable <= 4'hF;
        rd_chk("trim partial", rpsc_pkg::ADDR_REF_TRIM, 32'hFF800000);
        access(1'b1, rpsc_pkg::ADDR_REF_TRIM, 32'h00000000);
        for (int c = 0; c < 12; c++) begin
            src_mask <= ~(12'h001 << c);
            access(1'b1, rpsc_pkg::ADDR_REF_CTRL, 32'h00010000 | 32'(c));
            access(1'b1, rpsc_pkg::ADDR_REF_CTRL, 32'h00018000 | 32'(c));
            rd_chk("ref status", rpsc_pkg::ADDR_REF_CTRL, 32'h00018100 | 32'(c));
            count_rises(6, 128);
            check("ref unselected", 32'h0, r);
            src_mask <= 12'h001 << c;
            count_rises(6, 128);
            check("ref selected", 32'h1, 32'(r > 1));
            access(1'b1, rpsc_pkg::ADDR_REF_CTRL, 32'h00010000 | 32'(c));
        end
        unlock_wr(rpsc_pkg::ADDR_SLEW, 32'hFFFFFFFF);
        rd_chk("slew bits", rpsc_pkg::ADDR_SLEW, 32'h0F0F0706);
        check("sys_clock_divisor held", 32'h0, 32'(sys_clock_divisor_o));
        for (int i = 0; i < 5; i++) begin
            w = slw_word[i];
            unlock_wr(rpsc_pkg::ADDR_SLEW, w);
            rd_chk("slew word", rpsc_pkg::ADDR_SLEW, w);
            r = busy_cnt;
            access(1'b1, rpsc_pkg::ADDR_OSC_SWITCH, 32'h00000001);
            repeat (60) @(posedge clk_sys_i);
            check("slew cycles", 32'(slw_busy[i]), 32'(busy_cnt - r));
            check("sys_clock_divisor", 32'(w[19:16]), 32'(sys_clock_divisor_o));
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
